//--- hw/drive_status_pkg.sv
// Notes on behaviour
// - Status bit 0 set when initialised and not in configuration mode.
// - Bit 1 in energised-idle or running; bit 2 while running or stopping.
// - Bit 3 while unacknowledged fault exists; bit 6 in power-locked state.
// - Bit 4 when supply present; bit 5 low while acting on quick stop.
// - Bit 9 when command word comes from the communications command.
// - Bit 12 when jog reference is used or will be used.
// - Bit 13 when running reverse or reverse will apply.
// - Bit 14 when speed reference comes from the communications reference.
// - Bit 15 when run enable withdrawn or quick stop in progress.
// - Status word is readable at all times, whatever the command source.
// - Any trip disables the power stage immediately; motor coasts.
// - Each trip stays latched until an explicit reset.
// - A latched trip is not cleared while its cause persists.
// - Drive cannot be re-enabled until every latched trip is reset.
// - Each trip source has its own latch; several may be active.
// - When tripped show a two-digit identifier and flash the healthy indicator.
// - Stop key acknowledges the trip message; escape key removes it.
// - Warn when a source nears its trip, unless warning display is off. The code has no warning for the stack overcurrent or 200% current trips.
// - Count consecutive overcurrent events; warn at two, trip at five.
// - In volts-per-hertz mode trip when current over 200% for 1 s.
// - Stall trip after 200 s in current limit; warn beyond half.
// - Overload warns past half the inverse-time allowance, trips past all.
// - Faulted state ends only on reset command with no faults remaining.
// - Trips reset only on a rising edge of command word bit 7.
package drive_status_pkg;
	// Sequencer states as reported by the sequencer logic
	typedef enum logic [2:0] {
		SEQ_NOT_READY, SEQ_POWER_LOCKED, SEQ_READY, SEQ_ENERGISED_IDLE,
		SEQ_RUNNING, SEQ_QUICKSTOP, SEQ_FAULT_REACTION, SEQ_FAULTED
	} seq_state_t;
	localparam int NUM_TRIPS         = 7;
	// Trip indices; identifier shown is index plus one
	localparam int TRIP_OVERVOLT     = 0;
	localparam int TRIP_STACK_OI     = 1;
	localparam int TRIP_UNDERVOLT    = 2;
	localparam int TRIP_OVERCURRENT  = 3;
	localparam int TRIP_CURRENT_LIM  = 4;
	localparam int TRIP_STALL        = 5;
	localparam int TRIP_INVERSE_TIME = 6;
	// Command word fields
	localparam int CW_ENABLE_OP      = 3;
	localparam int CW_RESET_FAULT    = 7;
	localparam int CW_COMMS_CONTROL  = 10;
	localparam int CW_COMMS_REF      = 11;
	localparam int CW_JOG            = 12;
	localparam int CW_REVERSE        = 13;
	// Register byte offsets
	localparam logic [4:0] REG_STATUS   = 5'h00;
	localparam logic [4:0] REG_TRIPS    = 5'h04;
	localparam logic [4:0] REG_WARNINGS = 5'h08;
	localparam logic [4:0] REG_CONFIG   = 5'h0c;
	localparam logic [4:0] REG_STALL_MS = 5'h10;
	localparam logic [4:0] REG_INV_MS   = 5'h14;
	localparam logic [4:0] REG_PANEL    = 5'h18;
	// Config fields and reset values
	localparam int CFG_SHOW_WARN     = 0;
	localparam int CFG_VHZ_MODE      = 1;
	localparam logic [1:0]  CONFIG_RESET   = 2'h1;
	localparam logic [31:0] STALL_MS_RESET = 32'h00030d40;  // 200000 ms
	localparam logic [31:0] INV_MS_RESET   = 32'h0000ea60;  // 60000 ms
	// Timing
	localparam int CLK_PERIOD_NS  = 20;
	localparam int TICK_NS        = 1000000;                // 1 ms time base
	localparam int TICK_CYCLES    = TICK_NS / CLK_PERIOD_NS;
	localparam int VHZ_LIMIT_MS   = 1000;                   // 1 s over 200%
	localparam int BLINK_HALF_MS  = 250;
	localparam logic [2:0] OC_WARN_COUNT = 3'h2;
	localparam logic [2:0] OC_TRIP_COUNT = 3'h5;
	// Synchronised pin bit positions
	localparam int PIN_SUPPLY = 0;
	localparam int PIN_OV     = 1;
	localparam int PIN_OV_W   = 2;
	localparam int PIN_OI     = 3;
	localparam int PIN_UV     = 4;
	localparam int PIN_UV_W   = 5;
	localparam int PIN_OC     = 6;
	localparam int PIN_I200   = 7;
	localparam int PIN_ILIM   = 8;
	localparam int PIN_OVLD   = 9;
	localparam int PIN_STOP   = 10;
	localparam int PIN_ESC    = 11;
	localparam int NUM_PINS   = 12;
endpackage

//--- hw/trip_if.sv
`timescale 1ns/1ps
interface trip_if;
	logic [drive_status_pkg::NUM_TRIPS-1:0] setReq;
	logic [drive_status_pkg::NUM_TRIPS-1:0] cause;
	logic                                   clearReq;
	logic [drive_status_pkg::NUM_TRIPS-1:0] latched;
	logic [7:0]                             tripId;
	modport ctrl (output setReq, output cause, output clearReq, input latched, input tripId);
	modport bank (input setReq, input cause, input clearReq, output latched, output tripId);
endinterface

//--- hw/trip_latch_bank.sv
`timescale 1ns/1ps
module trip_latch_bank (
	input wire logic clk,   // System clock
	input wire logic rst,   // Async reset, active high
	trip_if.bank     trips  // Set, cause, clear and latch state
);
	logic [drive_status_pkg::NUM_TRIPS-1:0] latched_q;
	logic [7:0]                             tripId_q;
	logic [7:0]                             id_d;

	// One latch per source; set wins over a clear in the same cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			latched_q <= '0;
		end else if (trips.clearReq) begin
			latched_q <= (latched_q & trips.cause) | trips.setReq;
		end else begin
			latched_q <= latched_q | trips.setReq;
		end
	end

	// Lowest latched source gives the displayed two-digit identifier
	always_comb begin
		id_d = 8'h00;
		for (int i = drive_status_pkg::NUM_TRIPS - 1; i >= 0; i--) begin
			if (latched_q[i]) begin
				id_d = 8'((i + 1) / 10 * 16 + (i + 1) % 10);
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tripId_q <= 8'h00;
		end else begin
			tripId_q <= id_d;
		end
	end

	assign trips.latched = latched_q;
	assign trips.tripId  = tripId_q;
endmodule // trip_latch_bank

//--- hw/drive_status_and_trip_latch.sv
`timescale 1ns/1ps
module drive_status_and_trip_latch #(
	parameter int TICK_CYCLES = drive_status_pkg::TICK_CYCLES  // Clocks per 1 ms tick
) (
	input  wire logic                           clk,               // 50 MHz clock
	input  wire logic                           rst,               // Async reset, high
	input  wire logic [4:0]                     avs_address,       // Byte address
	input  wire logic                           avs_read,          // Read strobe
	input  wire logic                           avs_write,         // Write strobe
	input  wire logic [31:0]                    avs_writedata,     // Write data
	input  wire logic [3:0]                     avs_byteenable,    // Byte lanes
	output logic [31:0]                         avs_readdata,      // Read data
	output logic                                avs_waitrequest,   // Stall
	input  wire drive_status_pkg::seq_state_t   seqState,          // Sequencer state
	input  wire logic                           initDone,          // Initialised
	input  wire logic                           configMode,        // Configuration mode
	input  wire logic                           stoppingActive,    // Stop ramp running
	input  wire logic [15:0]                    commandWord,       // Active command word
	input  wire logic                           runRequest,        // Request to energise
	input  wire logic                           supplyPresentPin,  // Line supply pin
	input  wire logic                           overVoltPin,       // DC link over trip level
	input  wire logic                           overVoltWarnPin,   // DC link near trip
	input  wire logic                           stackOverIPin,     // Stack overcurrent
	input  wire logic                           underVoltPin,      // DC link under trip
	input  wire logic                           underVoltWarnPin,  // DC link near under
	input  wire logic                           overCurrentPin,    // Overcurrent event level
	input  wire logic                           current200Pin,     // Current above 200%
	input  wire logic                           currentLimitPin,   // In current limit
	input  wire logic                           overloadPin,       // Above inverse-time level
	input  wire logic                           stopKeyPin,        // Panel stop key
	input  wire logic                           escKeyPin,         // Panel escape key
	output logic [15:0]                         sequencerStatus,   // Status word
	output logic                                powerStageEnable,  // Gate drive enable
	output logic                                enableAllowed,     // No trips latched
	output logic [7:0]                          tripId,            // BCD trip identifier
	output logic                                panelMsgShown,     // Trip message on panel
	output logic                                panelMsgAcked,     // Message acknowledged
	output logic                                panelWarning,      // Warning on panel
	output logic                                healthyLed         // Healthy indicator
);
	localparam int NT = drive_status_pkg::NUM_TRIPS;

	trip_if trips ();

	trip_latch_bank u_trip_latch_bank (
		.clk   (clk),
		.rst   (rst),
		.trips (trips)
	);

	// Two-flop synchronisers on every pin input
	logic [drive_status_pkg::NUM_PINS-1:0] pinRaw;
	logic [drive_status_pkg::NUM_PINS-1:0] pinMeta_q;
	logic [drive_status_pkg::NUM_PINS-1:0] pin_q;
	logic [drive_status_pkg::NUM_PINS-1:0] pinPrev_q;
	assign pinRaw = {escKeyPin, stopKeyPin, overloadPin, currentLimitPin, current200Pin,
		overCurrentPin, underVoltWarnPin, underVoltPin, stackOverIPin, overVoltWarnPin,
		overVoltPin, supplyPresentPin};

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pinMeta_q <= '0;
			pin_q     <= '0;
			pinPrev_q <= '0;
		end else begin
			pinMeta_q <= pinRaw;
			pin_q     <= pinMeta_q;
			pinPrev_q <= pin_q;
		end
	end

	logic [drive_status_pkg::NUM_PINS-1:0] pinRise;
	assign pinRise = pin_q & ~pinPrev_q;

	// Fault reset acts only on a rising command bit 7
	logic resetBit_q;
	logic resetEdge;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			resetBit_q <= 1'b0;
		end else begin
			resetBit_q <= commandWord[drive_status_pkg::CW_RESET_FAULT];
		end
	end
	assign resetEdge = commandWord[drive_status_pkg::CW_RESET_FAULT] & ~resetBit_q;

	// Software registers
	logic [1:0]  config_q;
	logic [31:0] stallMs_q;
	logic [31:0] invMs_q;
	logic        ack_q;
	logic        wrEn;
	assign wrEn = avs_write & ack_q;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				old[b*8 +: 8] = wd[b*8 +: 8];
			end
		end
		return old;
	endfunction

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			config_q  <= drive_status_pkg::CONFIG_RESET;
			stallMs_q <= drive_status_pkg::STALL_MS_RESET;
			invMs_q   <= drive_status_pkg::INV_MS_RESET;
		end else if (wrEn) begin
			case (avs_address)
				drive_status_pkg::REG_CONFIG: begin
					config_q <= 2'(merge(32'(config_q), avs_writedata, avs_byteenable));
				end
				drive_status_pkg::REG_STALL_MS: begin
					stallMs_q <= merge(stallMs_q, avs_writedata, avs_byteenable);
				end
				drive_status_pkg::REG_INV_MS: begin
					invMs_q <= merge(invMs_q, avs_writedata, avs_byteenable);
				end
				default: begin
				end
			endcase
		end
	end

	// 1 ms time base shared by all timed trips
	logic [31:0] tickCnt_q;
	logic        tick;
	assign tick = (tickCnt_q == 32'(TICK_CYCLES - 1));
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tickCnt_q <= '0;
		end else if (tick) begin
			tickCnt_q <= '0;
		end else begin
			tickCnt_q <= tickCnt_q + 32'h1;
		end
	end

	// Consecutive overcurrent events; cleared only by an accepted reset
	logic [2:0] ocCount_q;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ocCount_q <= '0;
		end else if (resetEdge && !pin_q[drive_status_pkg::PIN_OC]) begin
			ocCount_q <= '0;
		end else if (pinRise[drive_status_pkg::PIN_OC] && ocCount_q < drive_status_pkg::OC_TRIP_COUNT) begin
			ocCount_q <= ocCount_q + 3'h1;
		end
	end

	// Time above 200% in volts-per-hertz mode
	logic [31:0] vhzMs_q;
	logic        vhzActive;
	assign vhzActive = config_q[drive_status_pkg::CFG_VHZ_MODE] & pin_q[drive_status_pkg::PIN_I200];
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			vhzMs_q <= '0;
		end else if (!vhzActive) begin
			vhzMs_q <= '0;
		end else if (tick && vhzMs_q < 32'(drive_status_pkg::VHZ_LIMIT_MS)) begin
			vhzMs_q <= vhzMs_q + 32'h1;
		end
	end

	// Time in current limit for stall detection
	logic [31:0] stallCnt_q;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stallCnt_q <= '0;
		end else if (!pin_q[drive_status_pkg::PIN_ILIM]) begin
			stallCnt_q <= '0;
		end else if (tick && stallCnt_q <= stallMs_q) begin
			stallCnt_q <= stallCnt_q + 32'h1;
		end
	end

	// Inverse-time allowance: fills while overloaded, drains otherwise
	logic [31:0] invAcc_q;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			invAcc_q <= '0;
		end else if (tick) begin
			if (pin_q[drive_status_pkg::PIN_OVLD]) begin
				if (invAcc_q <= invMs_q) begin
					invAcc_q <= invAcc_q + 32'h1;
				end
			end else if (invAcc_q != 32'h0) begin
				invAcc_q <= invAcc_q - 32'h1;
			end
		end
	end

	// Trip set requests and persisting causes per source
	logic [NT-1:0] setReq;
	logic [NT-1:0] cause;
	always_comb begin
		setReq = '0;
		cause  = '0;
		setReq[drive_status_pkg::TRIP_OVERVOLT]     = pin_q[drive_status_pkg::PIN_OV];
		cause[drive_status_pkg::TRIP_OVERVOLT]      = pin_q[drive_status_pkg::PIN_OV];
		setReq[drive_status_pkg::TRIP_STACK_OI]     = pin_q[drive_status_pkg::PIN_OI];
		cause[drive_status_pkg::TRIP_STACK_OI]      = pin_q[drive_status_pkg::PIN_OI];
		setReq[drive_status_pkg::TRIP_UNDERVOLT]    = pin_q[drive_status_pkg::PIN_UV];
		cause[drive_status_pkg::TRIP_UNDERVOLT]     = pin_q[drive_status_pkg::PIN_UV];
		setReq[drive_status_pkg::TRIP_OVERCURRENT]  = pinRise[drive_status_pkg::PIN_OC] &
			(ocCount_q == drive_status_pkg::OC_TRIP_COUNT - 3'h1);
		cause[drive_status_pkg::TRIP_OVERCURRENT]   = pin_q[drive_status_pkg::PIN_OC];
		setReq[drive_status_pkg::TRIP_CURRENT_LIM]  = (vhzMs_q >= 32'(drive_status_pkg::VHZ_LIMIT_MS));
		cause[drive_status_pkg::TRIP_CURRENT_LIM]   = vhzActive;
		setReq[drive_status_pkg::TRIP_STALL]        = (stallCnt_q > stallMs_q);
		cause[drive_status_pkg::TRIP_STALL]         = pin_q[drive_status_pkg::PIN_ILIM];
		setReq[drive_status_pkg::TRIP_INVERSE_TIME] = (invAcc_q > invMs_q);
		cause[drive_status_pkg::TRIP_INVERSE_TIME]  = pin_q[drive_status_pkg::PIN_OVLD];
	end

	assign trips.setReq   = setReq;
	assign trips.cause    = cause;
	assign trips.clearReq = resetEdge;

	logic anyLatched;
	assign anyLatched = |trips.latched;

	// Gate drive drops in the same cycle a trip is requested
	assign powerStageEnable = runRequest & ~anyLatched & ~(|setReq);
	assign enableAllowed    = ~anyLatched;

	// Faulted state ends on a reset edge once no latch remains
	logic faulted_q;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			faulted_q <= 1'b0;
		end else if (|setReq) begin
			faulted_q <= 1'b1;
		end else if (resetEdge && !anyLatched) begin
			faulted_q <= 1'b0;
		end
	end

	// Panel message: shown on new trip, stop acknowledges, escape removes
	logic msgShown_q;
	logic msgAcked_q;
	logic newTrip;
	assign newTrip = |(setReq & ~trips.latched);
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			msgShown_q <= 1'b0;
			msgAcked_q <= 1'b0;
		end else if (newTrip) begin
			msgShown_q <= 1'b1;
			msgAcked_q <= 1'b0;
		end else begin
			if (msgShown_q && pinRise[drive_status_pkg::PIN_STOP]) begin
				msgAcked_q <= 1'b1;
			end
			if (pinRise[drive_status_pkg::PIN_ESC]) begin
				msgShown_q <= 1'b0;
			end
		end
	end

	// Healthy indicator steady when clear, flashing when tripped
	logic [31:0] blinkMs_q;
	logic        led_q;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			blinkMs_q <= '0;
			led_q     <= 1'b1;
		end else if (!anyLatched) begin
			blinkMs_q <= '0;
			led_q     <= 1'b1;
		end else if (tick) begin
			if (blinkMs_q == 32'(drive_status_pkg::BLINK_HALF_MS - 1)) begin
				blinkMs_q <= '0;
				led_q     <= ~led_q;
			end else begin
				blinkMs_q <= blinkMs_q + 32'h1;
			end
		end
	end

	// Warnings per source; only the panel warning is gated by the display setting
	logic [NT-1:0] warn_q;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			warn_q <= '0;
		end else begin
			warn_q <= '0;
			warn_q[drive_status_pkg::TRIP_OVERVOLT]     <= pin_q[drive_status_pkg::PIN_OV_W];
			warn_q[drive_status_pkg::TRIP_UNDERVOLT]    <= pin_q[drive_status_pkg::PIN_UV_W];
			warn_q[drive_status_pkg::TRIP_OVERCURRENT]  <= (ocCount_q >= drive_status_pkg::OC_WARN_COUNT);
			warn_q[drive_status_pkg::TRIP_STALL]        <= (stallCnt_q > (stallMs_q >> 1));
			warn_q[drive_status_pkg::TRIP_INVERSE_TIME] <= (invAcc_q > (invMs_q >> 1));
		end
	end
	assign panelWarning = config_q[drive_status_pkg::CFG_SHOW_WARN] & (|warn_q);

	// Status word, rebuilt every cycle
	logic [15:0] status_d;
	logic [15:0] status_q;
	always_comb begin
		status_d     = 16'h0000;
		status_d[0]  = initDone & ~configMode;
		status_d[1]  = (seqState == drive_status_pkg::SEQ_ENERGISED_IDLE) ||
			(seqState == drive_status_pkg::SEQ_RUNNING);
		status_d[2]  = (seqState == drive_status_pkg::SEQ_RUNNING) | stoppingActive;
		status_d[3]  = anyLatched | faulted_q;
		status_d[4]  = pin_q[drive_status_pkg::PIN_SUPPLY];
		status_d[5]  = (seqState != drive_status_pkg::SEQ_QUICKSTOP);
		status_d[6]  = (seqState == drive_status_pkg::SEQ_POWER_LOCKED);
		status_d[9]  = commandWord[drive_status_pkg::CW_COMMS_CONTROL];
		status_d[12] = commandWord[drive_status_pkg::CW_JOG];
		status_d[13] = commandWord[drive_status_pkg::CW_REVERSE];
		status_d[14] = commandWord[drive_status_pkg::CW_COMMS_REF];
		status_d[15] = (~commandWord[drive_status_pkg::CW_ENABLE_OP] &
			(seqState == drive_status_pkg::SEQ_RUNNING)) |
			(seqState == drive_status_pkg::SEQ_QUICKSTOP);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			status_q <= 16'h0000;
		end else begin
			status_q <= status_d;
		end
	end

	// Bus slave: one wait cycle, then the answer at the next edge
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= (avs_read | avs_write) & ~ack_q;
		end
	end
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;

	// Read data captured in the wait cycle; status always readable
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			avs_readdata <= '0;
		end else if (avs_read && !ack_q) begin
			case (avs_address)
				drive_status_pkg::REG_STATUS:   avs_readdata <= {16'h0000, status_q};
				drive_status_pkg::REG_TRIPS:    avs_readdata <= 32'(trips.latched);
				drive_status_pkg::REG_WARNINGS: avs_readdata <= 32'(warn_q);
				drive_status_pkg::REG_CONFIG:   avs_readdata <= 32'(config_q);
				drive_status_pkg::REG_STALL_MS: avs_readdata <= stallMs_q;
				drive_status_pkg::REG_INV_MS:   avs_readdata <= invMs_q;
				drive_status_pkg::REG_PANEL:    avs_readdata <= {22'h0, msgAcked_q, msgShown_q, trips.tripId};
				default:                        avs_readdata <= 32'h0;
			endcase
		end
	end

	assign sequencerStatus = status_q;
	assign tripId          = trips.tripId;
	assign panelMsgShown   = msgShown_q;
	assign panelMsgAcked   = msgAcked_q;
	assign healthyLed      = led_q;
endmodule // drive_status_and_trip_latch

//--- tb/drive_status_asserts.sv
`timescale 1ns/1ps
module drive_status_asserts (
	input wire logic        clk,              // Clock
	input wire logic        rst,              // Reset
	input wire logic [15:0] commandWord,      // Command word
	input wire logic        initDone,         // Initialised
	input wire logic        configMode,       // Config mode
	input wire logic        supplyPresentPin, // Supply pin
	input wire logic        overVoltPin,      // Trip cause
	input wire logic [15:0] sequencerStatus,  // Status word
	input wire logic        powerStageEnable, // Gate enable
	input wire logic        enableAllowed,    // No latch set
	input wire logic [7:0]  tripId            // Trip number
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Cause held across the synchroniser
	sequence s_cause2; overVoltPin [*2]; endsequence
	sequence s_cause3; overVoltPin [*3]; endsequence
	a_coast_on_trip: assert property (s_cause2 |=> !powerStageEnable) else $error("gate on after trip");
	a_latch_holds: assert property (s_cause3 |=> !enableAllowed) else $error("latch clear with cause");
	a_reset_edge_only: assert property (!enableAllowed && !$rose(commandWord[7]) |=> !enableAllowed)
		else $error("latch cleared without reset edge");
	a_no_reenable: assert property (!enableAllowed |-> !powerStageEnable) else $error("gate on while latched");
	a_fault_bit: assert property (!enableAllowed |=> sequencerStatus[3]) else $error("fault bit low");
	a_trip_number: assert property (!enableAllowed |=> tripId inside {[8'h01:8'h07]}) else $error("bad id");
	a_unused_zero: assert property ((sequencerStatus & 16'h0d80) == 16'h0000)
		else $error("unused bits set");
	a_ready_bit: assert property (!$past(rst) |-> sequencerStatus[0] == ($past(initDone) && !$past(configMode)))
		else $error("ready bit wrong");
	// Sync stages plus status register
	a_supply_bit: assert property (!$past(rst) && !$past(rst, 2) && !$past(rst, 3) |->
		sequencerStatus[4] == $past(supplyPresentPin, 3)) else $error("supply bit wrong");
endmodule // drive_status_asserts

bind drive_status_and_trip_latch drive_status_asserts u_drive_status_asserts (.*);

//--- tb/drive_ctrl_model.sv
`timescale 1ns/1ps
module drive_ctrl_model (
	input wire logic        clk,         // Clock
	input wire logic        rst,         // Reset
	input wire logic [15:0] cmdBase,     // Wanted command bits
	input wire logic        resetReq,    // One-cycle reset request
	output logic [15:0]     commandWord  // Word to the drive
);
	logic [2:0] holdCnt_q;  // Cycles left with the reset bit high
	// Bit 7 falls again so each request is a fresh rising edge
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			holdCnt_q <= 3'h0;
		end else if (resetReq) begin
			holdCnt_q <= 3'h4;
		end else if (holdCnt_q != 3'h0) begin
			holdCnt_q <= holdCnt_q - 3'h1;
		end
	end
	assign commandWord = {cmdBase[15:8], holdCnt_q != 3'h0, cmdBase[6:0]};
endmodule // drive_ctrl_model

//--- tb/tb_drive_status_and_trip_latch.sv
`timescale 1ns/1ps
module tb_drive_status_and_trip_latch;
	logic        clk, rst, avs_read, avs_write, avs_waitrequest, initDone, configMode, stoppingActive, resetReq;
	logic        runRequest, powerStageEnable, enableAllowed, panelMsgShown, panelMsgAcked, panelWarning, healthyLed;
	logic [4:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic [15:0] cmdBase, commandWord, sequencerStatus;
	logic [11:0] pins;
	logic [7:0]  tripId;
	int          err_count, comparisons;
	drive_status_pkg::seq_state_t seqState;
	drive_status_and_trip_latch #(.TICK_CYCLES(4)) u_drive_status_and_trip_latch (.clk, .rst, .avs_address,
		.avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .seqState,
		.initDone, .configMode, .stoppingActive, .commandWord, .runRequest,
		.supplyPresentPin(pins[drive_status_pkg::PIN_SUPPLY]), .overVoltPin(pins[drive_status_pkg::PIN_OV]),
		.overVoltWarnPin(pins[drive_status_pkg::PIN_OV_W]), .stackOverIPin(pins[drive_status_pkg::PIN_OI]),
		.underVoltPin(pins[drive_status_pkg::PIN_UV]), .underVoltWarnPin(pins[drive_status_pkg::PIN_UV_W]),
		.overCurrentPin(pins[drive_status_pkg::PIN_OC]), .current200Pin(pins[drive_status_pkg::PIN_I200]),
		.currentLimitPin(pins[drive_status_pkg::PIN_ILIM]), .overloadPin(pins[drive_status_pkg::PIN_OVLD]),
		.stopKeyPin(pins[drive_status_pkg::PIN_STOP]), .escKeyPin(pins[drive_status_pkg::PIN_ESC]),
		.sequencerStatus, .powerStageEnable, .enableAllowed, .tripId, .panelMsgShown, .panelMsgAcked,
		.panelWarning, .healthyLed);
	drive_ctrl_model u_drive_ctrl_model (.clk, .rst, .cmdBase, .resetReq, .commandWord);
	// Free-running system clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic test_done;
		if (err_count == 0 && comparisons > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			err_count++;
			$display("CHECK FAILED %0t seen %h want %h", $time, s, e);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	// One bus cycle, held until waitrequest is low; bounded
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] r);
		int n = 0;
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0) begin
			n++;
			if (n > 20) begin
				err_count++;
				test_done();
			end
			@(posedge clk);
		end
		r = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic rdc(input logic [4:0] a, input logic [31:0] e);
		logic [31:0] d;
		bus(1'b0, a, 32'h0, d);
		chk(d, e);
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask
	task automatic rdt(input logic [31:0] e);
		rdc(drive_status_pkg::REG_TRIPS, e);
	endtask
	task automatic press(input int p);
		pins[p] <= 1'b1;
		cyc(4);
		pins[p] <= 1'b0;
		cyc(4);
	endtask
	task automatic pulseReset;
		@(posedge clk);
		resetReq <= 1'b1;
		@(posedge clk);
		resetReq <= 1'b0;
		cyc(8);
	endtask
	// Flags f = {supply, stopping, config mode, initialised}
	task automatic phase(input drive_status_pkg::seq_state_t s, input logic [15:0] c, input logic [3:0] f,
		input logic [31:0] e);
		seqState <= s;
		cmdBase <= c;
		{pins[drive_status_pkg::PIN_SUPPLY], stoppingActive, configMode, initDone} <= f;
		cyc(6);
		rdc(drive_status_pkg::REG_STATUS, e);
		chk({16'h0, sequencerStatus}, e);
	endtask
	// Trip latches, survives a reset while caused, then clears
	task automatic tripCase(input int p, input int n, input logic [31:0] m);
		pins[p] <= 1'b1;
		cyc(n);
		rdt(m);
		pulseReset();
		rdt(m);
		pins[p] <= 1'b0;
		cyc(n);
		pulseReset();
		rdt(32'h0);
		chk({31'h0, enableAllowed}, 32'h1);
	endtask
	task automatic panelCase;
		logic l;
		{pins[drive_status_pkg::PIN_OV], pins[drive_status_pkg::PIN_UV]} <= 2'h3;
		cyc(8);
		rdt(32'h05);
		chk({24'h0, tripId}, 32'h01);
		chk({31'h0, panelMsgShown}, 32'h1);
		l = healthyLed;
		cyc(1010);
		chk({31'h0, healthyLed}, {31'h0, ~l});
		press(drive_status_pkg::PIN_STOP);
		chk({31'h0, panelMsgAcked}, 32'h1);
		press(drive_status_pkg::PIN_ESC);
		chk({31'h0, panelMsgShown}, 32'h0);
		{pins[drive_status_pkg::PIN_OV], pins[drive_status_pkg::PIN_UV]} <= 2'h0;
		cyc(4);
		pulseReset();
		rdt(32'h0);
	endtask
	task automatic warnCase;
		pins[drive_status_pkg::PIN_OV_W] <= 1'b1;
		cyc(6);
		chk({31'h0, panelWarning}, 32'h1);
		wr(drive_status_pkg::REG_CONFIG, 32'h0);
		cyc(2);
		chk({31'h0, panelWarning}, 32'h0);
		pins[drive_status_pkg::PIN_OV_W] <= 1'b0;
		wr(drive_status_pkg::REG_CONFIG, 32'h1);
		rdc(5'h1c, 32'h0);
		for (int i = 1; i <= 5; i++) begin
			press(drive_status_pkg::PIN_OC);
			if (i == 2) rdc(drive_status_pkg::REG_WARNINGS, 32'h08);
			if (i == 4) rdt(32'h0);
		end
		rdt(32'h08);
		pulseReset();
		rdt(32'h0);
	endtask
	// Reset, status table, trips, panel
	initial begin
		{avs_read, avs_write, avs_address, avs_writedata, initDone, configMode, stoppingActive} = '0;
		{runRequest, resetReq, pins, cmdBase, err_count, comparisons} = '0;
		seqState = drive_status_pkg::SEQ_NOT_READY;
		rst = 1'b1;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		runRequest <= 1'b1;
		phase(drive_status_pkg::SEQ_RUNNING, 16'h3c08, 4'h9, 32'h7237);
		phase(drive_status_pkg::SEQ_POWER_LOCKED, 16'h0, 4'h1, 32'h0061);
		phase(drive_status_pkg::SEQ_QUICKSTOP, 16'h0, 4'h5, 32'h8005);
		phase(drive_status_pkg::SEQ_ENERGISED_IDLE, 16'h0, 4'h3, 32'h0022);
		phase(drive_status_pkg::SEQ_RUNNING, 16'h0, 4'h1, 32'h8027);
		phase(drive_status_pkg::SEQ_RUNNING, 16'h0008, 4'h9, 32'h0037);
		tripCase(drive_status_pkg::PIN_OV, 10, 32'h01);
		tripCase(drive_status_pkg::PIN_OI, 10, 32'h02);
		tripCase(drive_status_pkg::PIN_UV, 10, 32'h04);
		panelCase();
		warnCase();
		wr(drive_status_pkg::REG_CONFIG, 32'h3);
		tripCase(drive_status_pkg::PIN_I200, 4100, 32'h10);
		wr(drive_status_pkg::REG_STALL_MS, 32'ha);
		tripCase(drive_status_pkg::PIN_ILIM, 60, 32'h20);
		wr(drive_status_pkg::REG_INV_MS, 32'ha);
		tripCase(drive_status_pkg::PIN_OVLD, 60, 32'h40);
		test_done();
	end
endmodule // tb_drive_status_and_trip_latch
